// File: hw/stl_pkg.sv
// shared constants and types for the safety terminal status indicators
// assumes one 25 MHz system clock and a 32-bit Avalon-MM register port
package stl_pkg;

  // ----------------------------------------------------------------------
  // clock and blink timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ = 25_000_000;       // system clock rate
  localparam int FW_LOAD_HALF_MS = 1000;    // 0.5 Hz blink, half period
  localparam int FW_DONE_HALF_MS = 250;     // 2 Hz blink, half period
  localparam int IDENT_HALF_MS = 500;       // 1 Hz blink, half period
  localparam int FW_LOAD_HALF_CYC = (CLK_HZ / 1000) * FW_LOAD_HALF_MS;
  localparam int FW_DONE_HALF_CYC = (CLK_HZ / 1000) * FW_DONE_HALF_MS;
  localparam int IDENT_HALF_CYC = (CLK_HZ / 1000) * IDENT_HALF_MS;

  // ----------------------------------------------------------------------
  // channel counts
  // ----------------------------------------------------------------------
  localparam int N_PAIRS = 10;              // dual-channel input pairs
  localparam int N_SAFE_IN = 2 * N_PAIRS;   // single safe input lines
  localparam int N_DIG_IN = 4;              // plain digital inputs
  localparam int N_SAFE_OUT = 4;            // fail-safe outputs
  localparam int N_SUPPLY = 3;              // two switched, one fixed

  // ----------------------------------------------------------------------
  // register offsets (byte addresses) and fields
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;       // identify request
  localparam logic [7:0] REG_CONTACT = 8'h04;    // pair contact types
  localparam logic [7:0] REG_IRQ_STATUS = 8'h08; // sticky events, ro
  localparam logic [7:0] REG_IRQ_CLEAR = 8'h0c;  // write one to clear
  localparam logic [7:0] REG_IRQ_ENABLE = 8'h10; // interrupt mask
  localparam logic [7:0] REG_LED_STATE = 8'h14;  // indicator readback
  localparam int CTRL_IDENT_BIT = 0;
  localparam int IRQ_FAULT_BIT = 0;         // fault raised
  localparam int IRQ_SUPPLY_BIT = 1;        // a sensor supply failed
  localparam int IRQ_PAIR_BIT = 2;          // a pair went discrepant
  localparam int IRQ_FW_DONE_BIT = 3;       // firmware download finished
  localparam int IRQ_W = 4;
  localparam int LS_READY_POS = 0;          // ready colour {red,green}
  localparam int LS_MODE_POS = 4;           // ready mode, 3 bits
  localparam int LS_SUPPLY_POS = 8;         // supply red, 3 bits
  localparam int LS_PAIR_POS = 12;          // pair alarm, 10 bits
  localparam logic CTRL_RST = 1'b0;
  localparam logic [N_PAIRS-1:0] CONTACT_RST = 10'h000;
  localparam logic [IRQ_W-1:0] IRQ_EN_RST = 4'h0;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {LINK_DOWN, LINK_SETUP, LINK_RUN} stl_link_t;
  typedef enum logic [2:0] {
    RDY_OFF, RDY_RUN, RDY_SETUP, RDY_FAULT, RDY_FW_LOAD, RDY_FW_DONE,
    RDY_IDENT
  } stl_ready_mode_t;
  typedef struct packed {logic red; logic green;} stl_color_t;
  typedef stl_color_t [1:0] stl_pair_t;     // [0] input x, [1] input x+1
  typedef struct packed {
    logic [N_SAFE_IN-1:0] safeIn;           // safe input levels
    logic [N_DIG_IN-1:0] digIn;             // digital input levels
    logic [N_SAFE_OUT-1:0] outDrive;        // output actively driven
    logic [N_SAFE_OUT-1:0] linePos;         // readback of y+ line
    logic [N_SAFE_OUT-1:0] lineNeg;         // readback of y- line
    logic [N_SUPPLY-1:0] supplyFault;       // a,b switched; fixed
  } stl_pins_t;
  typedef struct packed {
    stl_link_t link;                        // drive link state
    logic fault;                            // at least one fault
    logic fwLoading;                        // firmware download running
    logic fwComplete;                       // one-cycle pulse at finish
  } stl_drive_t;
  typedef struct packed {
    stl_color_t ready;
    logic [N_SUPPLY-1:0] supplyRed;
    stl_color_t [N_SAFE_IN-1:0] safeLed;
    logic [N_DIG_IN-1:0] digInGreen;
    logic [N_SAFE_OUT-1:0] safeOutGreen;
    logic [N_SAFE_OUT-1:0] readbackGreen;
  } stl_leds_t;

endpackage : stl_pkg

// File: hw/stl_status_leds.sv
// status indicator logic of a fail-safe terminal module with its
// register port
// assumes all inputs synchronous to clk_sys; registers reached over
// Avalon-MM with waitrequest; one clock, asynchronous active-high reset
`timescale 1ns/1ps
`default_nettype none

// Operation
// - ready green when running, link cyclic
// - ready orange while link is set up
// - ready red on any fault outside download, download done and identify
// - download: green/red blink at 0.5 Hz
// - download done: green/red 2 Hz until repower
// - identify: 1 Hz blink with orange
// - switched supply LEDs red on fault
// - fixed supply LED red on fault
// - break/break: x+1 red on disagreement
// - break/make: x+1 red when states equal
// - break/break: both green when both high
// - break/make: green when x high, x+1 low
// - pair dark when both inputs low
// - digital input LED green when signal
// - safe output LED green while driven
// - readback green only when both lines low
module stl_status_leds
  import stl_pkg::*;
#(
  parameter int FW_LOAD_HALF = FW_LOAD_HALF_CYC,  // 0.5 Hz half period
  parameter int FW_DONE_HALF = FW_DONE_HALF_CYC,  // 2 Hz half period
  parameter int IDENT_HALF = IDENT_HALF_CYC       // 1 Hz half period
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  input wire stl_pins_t pins,
  input wire stl_drive_t drive,
  output stl_leds_t ledOut,
  output logic irq
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------

  // merge a write under byte enables, so partial writes keep other bytes
  function automatic logic [31:0] byteMerge(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res;
  endfunction : byteMerge

  // indicator pair of one dual-channel input, per its contact type
  function automatic stl_pair_t pairDecode(input logic a, input logic b,
      input logic breakMake);
    stl_pair_t res;
    res = '0;
    if (!a && !b) begin
      res = '0;                             // both low: dark
    end else if (!breakMake) begin
      if (a != b) begin
        res[1].red = 1'b1;                  // discrepancy
      end else begin
        res[0].green = 1'b1;                // both closed
        res[1].green = 1'b1;
      end
    end else if (a == b) begin
      res[1].red = 1'b1;                    // equal states
    end else if (a && !b) begin
      res[0].green = 1'b1;                  // normal state
      res[1].green = 1'b1;
    end
    return res;
  endfunction : pairDecode

  // ----------------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------------
  logic [31:0] ctrlWord;                    // byte-merged control write
  logic [31:0] contactWord;                 // byte-merged contact write
  logic [31:0] clearWord;                   // byte-merged clear write
  logic [31:0] enableWord;                  // byte-merged enable write
  logic busReq;                             // request presented
  logic wrTake;                             // write completes this edge
  logic identReq;                           // identify request setting
  logic [N_PAIRS-1:0] contactBreakMake;     // 1 = break/make pair
  logic [IRQ_W-1:0] irqStatus;              // sticky events
  logic [IRQ_W-1:0] irqEnable;              // interrupt mask
  logic [31:0] next_readData;               // decoded read value
  stl_ready_mode_t readyMode;               // current ready mode
  logic [N_PAIRS-1:0] pairAlarm;            // x+1 red per pair

  assign busReq = avsRead | avsWrite;
  assign wrTake = avsWrite & ~avsWaitRequest;
  assign ctrlWord = byteMerge({31'h0, identReq}, avsWriteData,
      avsByteEnable);
  assign contactWord = byteMerge({22'h0, contactBreakMake}, avsWriteData,
      avsByteEnable);
  assign clearWord = byteMerge(32'h0, avsWriteData, avsByteEnable);
  assign enableWord = byteMerge({28'h0, irqEnable}, avsWriteData,
      avsByteEnable);

  // one wait cycle per access: the request is seen with waitrequest
  // high, then waitrequest drops for exactly one cycle
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      avsWaitRequest <= 1'b1;
    end else if (busReq && avsWaitRequest) begin
      avsWaitRequest <= 1'b0;
    end else begin
      avsWaitRequest <= 1'b1;
    end
  end

  // read decode; unmapped offsets and the clear register read as zero
  always_comb begin
    next_readData = 32'h0;
    case (avsAddress)
      REG_CTRL: next_readData[CTRL_IDENT_BIT] = identReq;
      REG_CONTACT: next_readData[N_PAIRS-1:0] = contactBreakMake;
      REG_IRQ_STATUS: next_readData[IRQ_W-1:0] = irqStatus;
      REG_IRQ_ENABLE: next_readData[IRQ_W-1:0] = irqEnable;
      REG_LED_STATE: begin
        next_readData[LS_READY_POS +: 2] = ledOut.ready;
        next_readData[LS_MODE_POS +: 3] = readyMode;
        next_readData[LS_SUPPLY_POS +: N_SUPPLY] = ledOut.supplyRed;
        next_readData[LS_PAIR_POS +: N_PAIRS] = pairAlarm;
      end
      default: next_readData = 32'h0;
    endcase
  end

  // read data is captured while waitrequest is high and stands through
  // the edge at which the master samples waitrequest low
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      avsReadData <= 32'h0;
    end else if (avsRead && avsWaitRequest) begin
      avsReadData <= next_readData;
    end
  end

  // control and contact type registers, written by the controller
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      identReq <= CTRL_RST;
      contactBreakMake <= CONTACT_RST;
    end else if (wrTake && avsAddress == REG_CTRL) begin
      identReq <= ctrlWord[CTRL_IDENT_BIT];
    end else if (wrTake && avsAddress == REG_CONTACT) begin
      contactBreakMake <= contactWord[N_PAIRS-1:0];
    end
  end

  // interrupt mask
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irqEnable <= IRQ_EN_RST;
    end else if (wrTake && avsAddress == REG_IRQ_ENABLE) begin
      irqEnable <= enableWord[IRQ_W-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // blink time base
  // ----------------------------------------------------------------------
  // three free-running half-period counters; they are never restarted,
  // so a blink may open with a short first phase, which the eye ignores
  localparam int HALF_ARR [3] = '{FW_LOAD_HALF, FW_DONE_HALF, IDENT_HALF};
  logic [2:0] blinkPhase;                   // 0 fw load, 1 done, 2 ident

  genvar gb;
  generate
    for (gb = 0; gb < 3; gb++) begin : g_blink
      logic [31:0] halfCnt;                 // cycles into this half
      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          halfCnt <= 32'h0;
          blinkPhase[gb] <= 1'b0;
        end else if (halfCnt == 32'(HALF_ARR[gb] - 1)) begin
          halfCnt <= 32'h0;
          blinkPhase[gb] <= ~blinkPhase[gb];
        end else begin
          halfCnt <= halfCnt + 32'h1;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // readiness indicator
  // ----------------------------------------------------------------------
  logic fwDone;                             // held until power cycle
  stl_color_t next_ready;                   // colour for next cycle

  // the completed-download state only leaves by reset (power on)
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      fwDone <= 1'b0;
    end else if (drive.fwComplete) begin
      fwDone <= 1'b1;
    end
  end

  // mode precedence
  always_comb begin
    if (identReq) begin
      readyMode = RDY_IDENT;
    end else if (drive.fwLoading) begin
      readyMode = RDY_FW_LOAD;
    end else if (fwDone) begin
      readyMode = RDY_FW_DONE;
    end else if (drive.fault) begin
      readyMode = RDY_FAULT;
    end else if (drive.link == LINK_SETUP) begin
      readyMode = RDY_SETUP;
    end else if (drive.link == LINK_RUN) begin
      readyMode = RDY_RUN;
    end else begin
      readyMode = RDY_OFF;
    end
  end

  // colour of each mode; orange is red and green together
  always_comb begin
    next_ready = '0;
    case (readyMode)
      RDY_RUN: next_ready.green = 1'b1;
      RDY_SETUP: next_ready = '{1'b1, 1'b1};
      RDY_FAULT: next_ready.red = 1'b1;
      RDY_FW_LOAD: begin
        next_ready.red = blinkPhase[0];
        next_ready.green = ~blinkPhase[0];
      end
      RDY_FW_DONE: begin
        next_ready.red = blinkPhase[1];
        next_ready.green = ~blinkPhase[1];
      end
      RDY_IDENT: begin
        // orange phase, else the fault-dependent colour
        next_ready.red = blinkPhase[2] | drive.fault;
        next_ready.green = blinkPhase[2] | ~drive.fault;
      end
      default: next_ready = '0;
    endcase
  end

  // ----------------------------------------------------------------------
  // channel indicators
  // ----------------------------------------------------------------------
  stl_color_t [N_SAFE_IN-1:0] next_safeLed; // decoded pair indicators

  genvar gp;
  generate
    for (gp = 0; gp < N_PAIRS; gp++) begin : g_pair
      stl_pair_t pr;
      assign pr = pairDecode(pins.safeIn[2*gp], pins.safeIn[2*gp+1],
          contactBreakMake[gp]);
      assign next_safeLed[2*gp] = pr[0];
      assign next_safeLed[2*gp+1] = pr[1];
      assign pairAlarm[gp] = ledOut.safeLed[2*gp+1].red;
    end
  endgenerate

  // every indicator is registered so the pins never see decode glitches
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ledOut <= '0;
    end else begin
      ledOut.ready <= next_ready;
      ledOut.supplyRed[1:0] <= pins.supplyFault[1:0];
      ledOut.supplyRed[2] <= pins.supplyFault[2];
      ledOut.safeLed <= next_safeLed;
      ledOut.digInGreen <= pins.digIn;
      ledOut.safeOutGreen <= pins.outDrive;
      ledOut.readbackGreen <= ~(pins.linePos | pins.lineNeg);
    end
  end

  // ----------------------------------------------------------------------
  // events and interrupt
  // ----------------------------------------------------------------------
  logic prevFault;                          // fault one cycle ago
  logic [N_SUPPLY-1:0] prevSupply;          // supply faults one ago
  logic [N_PAIRS-1:0] prevAlarm;            // pair alarms one ago
  logic [IRQ_W-1:0] irqEvent;               // rising-edge events

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      prevFault <= 1'b0;
      prevSupply <= '0;
      prevAlarm <= '0;
    end else begin
      prevFault <= drive.fault;
      prevSupply <= pins.supplyFault;
      prevAlarm <= pairAlarm;
    end
  end

  assign irqEvent[IRQ_FAULT_BIT] = drive.fault & ~prevFault;
  assign irqEvent[IRQ_SUPPLY_BIT] = |(pins.supplyFault & ~prevSupply);
  assign irqEvent[IRQ_PAIR_BIT] = |(pairAlarm & ~prevAlarm);
  assign irqEvent[IRQ_FW_DONE_BIT] = drive.fwComplete & ~fwDone;

  // a new event in the clearing cycle survives: set wins over clear
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irqStatus <= '0;
    end else if (wrTake && avsAddress == REG_IRQ_CLEAR) begin
      irqStatus <= (irqStatus & ~clearWord[IRQ_W-1:0]) | irqEvent;
    end else begin
      irqStatus <= irqStatus | irqEvent;
    end
  end

  // registered level; follows status and mask one cycle later
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatus & irqEnable);
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  logic armed;                              // one cycle past reset
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      armed <= 1'b0;
    end else begin
      armed <= 1'b1;
    end
  end

  ready_run_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    armed && $past(readyMode) == RDY_RUN |-> ledOut.ready == 2'b01)
    else $error("ready not green while running");
  ready_setup_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    armed && $past(drive.link) == LINK_SETUP && !$past(drive.fault)
    && !$past(identReq) && !$past(drive.fwLoading) && !$past(fwDone)
    |-> ledOut.ready == 2'b11)
    else $error("ready not orange during link setup");
  ready_fault_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    armed && $past(drive.fault) && !$past(identReq)
    && !$past(drive.fwLoading) && !$past(fwDone) |-> ledOut.ready == 2'b10)
    else $error("ready not red on fault");
  fw_blink_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    armed && $past(readyMode) == RDY_FW_LOAD
    |-> ledOut.ready.red == $past(blinkPhase[0])
    && ledOut.ready.green != ledOut.ready.red)
    else $error("download blink wrong");
  fw_done_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    fwDone |=> fwDone && (identReq || drive.fwLoading
    || readyMode == RDY_FW_DONE))
    else $error("download-complete state lost");
  ident_blink_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    armed && $past(identReq) |-> ledOut.ready == 2'b11
    || ledOut.ready == {$past(drive.fault), !$past(drive.fault)})
    else $error("identify blink wrong");
  supply_led_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    armed |-> ledOut.supplyRed == $past(pins.supplyFault))
    else $error("supply indicator wrong");
  digin_led_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    armed |-> ledOut.digInGreen == $past(pins.digIn))
    else $error("digital input indicator wrong");
  out_led_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    armed |-> ledOut.safeOutGreen == $past(pins.outDrive))
    else $error("output indicator wrong");
  readback_led_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    armed && ledOut.readbackGreen[0] |-> !$past(pins.linePos[0])
    && !$past(pins.lineNeg[0]))
    else $error("readback green with a line high");
  pair_mismatch_a: assert property (@(posedge clk_sys)
    disable iff (sys_rst) armed && !$past(contactBreakMake[0])
    && $past(pins.safeIn[0]) != $past(pins.safeIn[1])
    |-> ledOut.safeLed[1] == 2'b10 && ledOut.safeLed[0] == 2'b00)
    else $error("pair discrepancy not red");
  pair_equal_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    armed && $past(contactBreakMake[0]) && $past(pins.safeIn[0])
    && $past(pins.safeIn[1]) |-> ledOut.safeLed[1].red)
    else $error("break/make equal not red");
  pair_green_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    armed && !$past(contactBreakMake[0]) && $past(pins.safeIn[0])
    && $past(pins.safeIn[1])
    |-> ledOut.safeLed[0] == 2'b01 && ledOut.safeLed[1] == 2'b01)
    else $error("break/break closed pair not green");
  pair_ok_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    armed && $past(pins.safeIn[0]) && !$past(pins.safeIn[1])
    && $past(contactBreakMake[0])
    |-> ledOut.safeLed[0] == 2'b01 && ledOut.safeLed[1] == 2'b01)
    else $error("break/make normal not green");
  pair_dark_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    armed && !$past(pins.safeIn[0]) && !$past(pins.safeIn[1])
    |-> ledOut.safeLed[1:0] == '0)
    else $error("idle pair not dark");
  bus_answer_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    busReq && avsWaitRequest |=> !avsWaitRequest)
    else $error("waitrequest did not drop after one cycle");
  irq_level_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    armed |-> irq == |($past(irqStatus) & $past(irqEnable)))
    else $error("interrupt level wrong");

  ident_seen_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
    identReq && ledOut.ready == 2'b11);
  fw_seen_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
    readyMode == RDY_FW_DONE);
  pair_red_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
    |pairAlarm);
  irq_seen_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
    irq);

endmodule : stl_status_leds

`default_nettype wire

// File: sim/stl_drive_model.sv
// drive controller stand-in: link state, fault and firmware download
// assumes the bench steers it through plain request levels on clk_sys
`timescale 1ns/1ps
`default_nettype none
module stl_drive_model
  import stl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire stl_link_t linkReq, // wanted link state
  input wire logic faultReq, // fault present
  input wire logic loadReq, // download running
  output stl_drive_t drive
);
  // ----
  // status to the terminal; one pulse when a download ends
  // ----
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      drive <= '0;
    end else begin
      drive.link <= linkReq;
      drive.fault <= faultReq;
      drive.fwLoading <= loadReq;
      drive.fwComplete <= drive.fwLoading & ~loadReq; // falling edge only
    end
  end
endmodule : stl_drive_model
`default_nettype wire

// File: sim/stl_status_leds_tb_top.sv
// self-checking bench for the status indicator block
// assumes stl_pkg and the drive controller model are compiled first
`timescale 1ns/1ps
`default_nettype none
module stl_status_leds_tb_top
  import stl_pkg::*;
;
  // ----
  // stimulus, model state and counters
  // ----
  logic clk_sys = 0, sys_rst = 1, avsRead = 0, avsWrite = 0;
  logic faultReq = 0, loadReq = 0, avsWaitRequest, irq;
  logic [7:0] avsAddress = '0;
  logic [31:0] avsWriteData = '0, avsReadData, q;
  logic [63:0] r;
  stl_pins_t pins = '0;
  stl_link_t linkReq = LINK_DOWN;
  stl_drive_t drive;
  stl_leds_t ledOut, exp;
  int badCount = 0, nChecks = 0, seed = 32'h31e8;
  always #20 clk_sys = ~clk_sys;
  // short blink halves keep the run brief
  stl_status_leds #(.FW_LOAD_HALF(8), .FW_DONE_HALF(4), .IDENT_HALF(6)) DUT (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsByteEnable(4'hf), .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest), .pins(pins), .drive(drive),
    .ledOut(ledOut), .irq(irq));
  stl_drive_model DRV (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .linkReq(linkReq), .faultReq(faultReq), .loadReq(loadReq),
    .drive(drive));
  // ----
  // compare, verdict and bus cycle
  // ----
  task automatic chk(input logic [63:0] got, want, input string m);
    nChecks++;
    if (got !== want) begin
      badCount++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk
  task automatic giveVerdict;
    $display("checks %0d mismatches %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : giveVerdict
  // holds the request until waitrequest is sampled low, bounded wait
  task automatic bus(input logic w, input logic [7:0] a, input int d);
    int n = 0;
    @(posedge clk_sys);
    avsAddress <= a;
    avsWrite <= w;
    avsRead <= ~w;
    avsWriteData <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avsWaitRequest !== 1'b0 && n < 50);
    q = avsReadData;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    if (n >= 50) begin
      badCount++;
      giveVerdict();
    end
  endtask : bus
  // mode index, then colour shares over 48 cycles (whole blink periods)
  task automatic rdy(input stl_ready_mode_t md, input logic [1:0] ca, cb);
    int na = 0, nb = 0, w = (ca == cb) ? 48 : 24;
    repeat (6) @(posedge clk_sys);
    bus(0, REG_LED_STATE, 0);
    chk(q[6:4], md, "mode");
    repeat (48) begin
      @(posedge clk_sys);
      na += (ledOut.ready === ca);
      nb += (ledOut.ready === cb);
    end
    chk({na, nb}, {w, w}, "blink");
  endtask : rdy
  // per-channel indicator model, ready colour left out
  function automatic stl_leds_t model(input stl_pins_t p, logic [9:0] c);
    stl_leds_t e = '0;
    e.supplyRed = p.supplyFault;
    e.digInGreen = p.digIn;
    e.safeOutGreen = p.outDrive;
    e.readbackGreen = ~(p.linePos | p.lineNeg);
    for (int z = 0; z < N_PAIRS; z++) begin
      e.safeLed[2*z].green = p.safeIn[2*z] & (c[z] ^ p.safeIn[2*z+1]);
      e.safeLed[2*z+1].green = e.safeLed[2*z].green;
      e.safeLed[2*z+1].red = c[z] ? &p.safeIn[2*z+:2] : ^p.safeIn[2*z+:2];
    end
    return e;
  endfunction : model
  initial begin
    repeat (20) @(posedge clk_sys);
    chk({ledOut, irq}, '0, "reset");
    sys_rst <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      r = {$random(seed), $random(seed)};
      bus(1, REG_CONTACT, r[49:40]);
      pins <= r[38:0];
      repeat (3) @(posedge clk_sys);
      exp = model(pins, r[49:40]);
      chk(ledOut[54:52], exp[54:52], "s");
      chk(ledOut[51:32], exp[51:32], "p");
      chk(ledOut[31:12], exp[31:12], "p");
      chk(ledOut[11:0], exp[11:0], "io");
    end
    $display("channel test done");
    rdy(RDY_OFF, 2'b00, 2'b00);
    linkReq <= LINK_RUN;
    rdy(RDY_RUN, 2'b01, 2'b01);
    linkReq <= LINK_SETUP;
    rdy(RDY_SETUP, 2'b11, 2'b11);
    faultReq <= 1'b1;
    rdy(RDY_FAULT, 2'b10, 2'b10);
    bus(1, REG_CTRL, 1);
    rdy(RDY_IDENT, 2'b10, 2'b11);
    bus(1, REG_CTRL, 0);
    loadReq <= 1'b1;
    rdy(RDY_FW_LOAD, 2'b01, 2'b10);
    loadReq <= 1'b0;
    faultReq <= 1'b0;
    rdy(RDY_FW_DONE, 2'b01, 2'b10);
    bus(1, REG_CTRL, 1);
    rdy(RDY_IDENT, 2'b01, 2'b11);
    $display("ready test done");
    bus(1, REG_IRQ_CLEAR, 32'hf);
    faultReq <= 1'b1;
    repeat (3) @(posedge clk_sys);
    bus(0, REG_IRQ_STATUS, 0);
    chk({q, irq}, 33'h2, "event masked");
    bus(1, REG_IRQ_ENABLE, 1);
    repeat (2) @(posedge clk_sys);
    chk(irq, 1, "irq");
    bus(1, REG_IRQ_CLEAR, 1);
    repeat (2) @(posedge clk_sys);
    bus(0, 8'h20, 32'hff);
    chk({q, irq}, '0, "cleared");
    $display("irq test done");
    giveVerdict();
  end
endmodule : stl_status_leds_tb_top
`default_nettype wire
